// >>> verilog/rx_ctrl_pkg.sv
// constants and carriers for the receive-path control registers
// assumes one csr clock; word addressing on the csr port
package rx_ctrl_pkg;

  // csr word address width covers offsets 0x00..0xff
  localparam int CSR_AW = 8;

  // word offsets
  localparam logic [CSR_AW-1:0] OFS_ENA_CTRL = 8'h00;
  localparam logic [CSR_AW-1:0] OFS_ENA_STAT = 8'h01;
  localparam logic [CSR_AW-1:0] OFS_STRIP    = 8'h40;
  localparam logic [CSR_AW-1:0] OFS_VERIFY   = 8'h80;

  // reset values
  localparam logic [31:0] RST_ENA_CTRL = 32'h0;
  localparam logic [31:0] RST_STRIP    = 32'h1;
  localparam logic [31:0] RST_VERIFY   = 32'h2;

  // field positions
  localparam int BIT_RX_OFF    = 0;
  localparam int BIT_FCS_STRIP = 0;
  localparam int BIT_PAD_STRIP = 1;
  localparam int BIT_VERIFY_EN = 1;

  // frame layout
  localparam int FCS_LEN     = 4;
  localparam int HDR_LEN     = 14;
  localparam int MIN_PAYLOAD = 46;

  // reflected crc-32 with its good-frame residue
  localparam logic [31:0] CRC_POLY    = 32'hedb88320;
  localparam logic [31:0] CRC_INIT    = 32'hffffffff;
  localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

  typedef struct packed {
    logic              read;
    logic              write;
    logic [CSR_AW-1:0] addr;
    logic [31:0]       wdata;
  } csr_req_s;

  typedef struct packed {
    logic       valid;
    logic       sop;
    logic       eop;
    logic [7:0] data;
  } rx_beat_s;

  typedef struct packed {
    logic path_off;
    logic fcs_strip;
    logic pad_strip;
  } strip_cfg_s;

endpackage

// >>> verilog/rx_frame_trim.sv
// byte stream stage: frame drop, fcs strip and pad strip
// assumes frames arrive on the csr clock, framed by sop and eop
`timescale 1ns/100ps

module rx_frame_trim (
  input  wire logic                    i_clk,
  input  wire logic                    i_sys_rst,
  input  wire rx_ctrl_pkg::strip_cfg_s i_cfg,
  input  wire rx_ctrl_pkg::rx_beat_s   i_beat,
  output rx_ctrl_pkg::rx_beat_s        o_beat,
  output logic                         o_path_off
);
  import rx_ctrl_pkg::*;

  typedef struct packed {
    logic [FCS_LEN-1:0][7:0] line;
    logic [2:0]              fill;
    logic [15:0]             in_cnt;
    logic [15:0]             out_cnt;
    logic [15:0]             len;
    logic                    in_frame;
    logic                    drop;
    logic                    fcs_rm;
    logic                    pad_rm;
    logic                    done;
    logic                    path_off;
    rx_beat_s                out;
  } trim_state_s;

  trim_state_s q;
  trim_state_s d;

  // settings are latched at sop so a change never tears a frame
  always_comb begin
    logic        emit;
    logic        last;
    logic [7:0]  byte_c;
    logic [15:0] lim;
    d = q;
    d.out = '0;
    emit = 1'b0;
    last = 1'b0;
    byte_c = 8'h00;
    lim = 16'hffff;
    if (!q.in_frame) begin
      d.path_off = i_cfg.path_off;
    end
    if (i_beat.valid && (i_beat.sop || q.in_frame)) begin
      if (i_beat.sop) begin
        d.drop = i_cfg.path_off;
        d.path_off = i_cfg.path_off;
        // pad bit wins over fcs bit
        d.fcs_rm = i_cfg.pad_strip | i_cfg.fcs_strip;
        d.pad_rm = i_cfg.pad_strip;
        d.fill = 3'd0;
        d.in_cnt = 16'h0;
        d.out_cnt = 16'h0;
        d.len = 16'hffff;
        d.done = 1'b0;
      end
      d.in_frame = !i_beat.eop;
      // length/type field, high byte first
      if (d.in_cnt == 16'(HDR_LEN - 2)) begin
        d.len = {i_beat.data, 8'hff};
      end else if (d.in_cnt == 16'(HDR_LEN - 1)) begin
        d.len[7:0] = i_beat.data;
      end
      if (d.in_cnt != 16'hffff) begin
        d.in_cnt = d.in_cnt + 16'h1;
      end
      if (!d.fcs_rm) begin
        emit = 1'b1;
        byte_c = i_beat.data;
        last = i_beat.eop;
      end else begin
        // fcs strip, hold last four bytes back
        if (d.fill == 3'(FCS_LEN)) begin
          emit = 1'b1;
          byte_c = q.line[FCS_LEN-1];
          last = i_beat.eop;
        end else begin
          d.fill = d.fill + 3'd1;
        end
        d.line = {q.line[FCS_LEN-2:0], i_beat.data};
      end
      if (d.pad_rm && d.len < 16'(MIN_PAYLOAD)) begin
        lim = 16'(HDR_LEN) + d.len;
        if (d.out_cnt >= lim) begin
          emit = 1'b0;
        end else if (d.out_cnt == lim - 16'h1) begin
          last = 1'b1;
        end
      end
      // trimmed bytes reach the client output
      if (emit && !d.done && !d.drop) begin
        d.out.valid = 1'b1;
        d.out.sop = (d.out_cnt == 16'h0);
        d.out.eop = last;
        d.out.data = byte_c;
      end
      if (emit && d.out_cnt != 16'hffff) begin
        d.out_cnt = d.out_cnt + 16'h1;
      end
      if (emit && last) begin
        d.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_beat = q.out;
  assign o_path_off = q.path_off;

endmodule

// >>> verilog/rx_path_control_regs.sv
// receive-path control and status registers with fcs checker
// assumes the csr port and rx stream share i_clk; reads answer next cycle
`timescale 1ns/100ps

module rx_path_control_regs (
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  input  wire rx_ctrl_pkg::csr_req_s i_csr,
  output logic [31:0]                o_csr_rdata,
  output logic                       o_csr_rdvalid,
  input  wire rx_ctrl_pkg::rx_beat_s i_rx,
  output rx_ctrl_pkg::rx_beat_s      o_receive_stream_data_out,
  output logic                       o_fcs_err
);
  import rx_ctrl_pkg::*;

  // every assertion below samples on the csr clock, quiet in reset
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  typedef struct packed {
    logic        rx_off;
    logic        fcs_strip;
    logic        pad_strip;
    logic        verify_en;
    logic [31:0] rdata;
    logic        rdvalid;
    logic [31:0] crc;
    logic        in_frame;
    logic        chk_on;
    logic        fcs_err;
  } regs_state_s;

  localparam regs_state_s STATE_RST = '{
    rx_off:    RST_ENA_CTRL[BIT_RX_OFF],
    fcs_strip: RST_STRIP[BIT_FCS_STRIP],
    pad_strip: RST_STRIP[BIT_PAD_STRIP],
    verify_en: RST_VERIFY[BIT_VERIFY_EN],
    default:   '0
  };

  regs_state_s q;
  regs_state_s d;
  strip_cfg_s  cfg;
  logic        path_off;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_strip;
  logic        hit_verify;

  // one byte of reflected crc-32, lsb first
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ b[i]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction

  // address decode; anything else is reserved space
  assign hit_ctrl   = (i_csr.addr == OFS_ENA_CTRL);
  assign hit_stat   = (i_csr.addr == OFS_ENA_STAT);
  assign hit_strip  = (i_csr.addr == OFS_STRIP);
  assign hit_verify = (i_csr.addr == OFS_VERIFY);

  // control bits steering the frame stage
  assign cfg.path_off  = q.rx_off;
  assign cfg.fcs_strip = q.fcs_strip;
  assign cfg.pad_strip = q.pad_strip;

  // next state: csr writes, read mux and fcs checker
  always_comb begin
    logic [31:0] crc_c;
    logic        chk_c;
    d = q;
    crc_c = q.crc;
    chk_c = q.chk_on;
    d.rdvalid = i_csr.read;
    d.rdata = 32'h0;
    d.fcs_err = 1'b0;
    if (i_csr.write) begin
      if (hit_ctrl) begin
        d.rx_off = i_csr.wdata[BIT_RX_OFF];
      end
      if (hit_strip) begin
        d.fcs_strip = i_csr.wdata[BIT_FCS_STRIP];
        d.pad_strip = i_csr.wdata[BIT_PAD_STRIP];
      end
      if (hit_verify) begin
        d.verify_en = i_csr.wdata[BIT_VERIFY_EN];
      end
    end
    if (i_csr.read) begin
      if (hit_ctrl) begin
        d.rdata[BIT_RX_OFF] = q.rx_off;
      end
      if (hit_stat) begin
        // live state of the frame stage
        d.rdata[BIT_RX_OFF] = path_off;
      end
      if (hit_strip) begin
        d.rdata[BIT_FCS_STRIP] = q.fcs_strip;
        d.rdata[BIT_PAD_STRIP] = q.pad_strip;
      end
      if (hit_verify) begin
        d.rdata[BIT_VERIFY_EN] = q.verify_en;
      end
    end
    // check runs on the unstripped input stream
    if (i_rx.valid && (i_rx.sop || q.in_frame)) begin
      if (i_rx.sop) begin
        crc_c = CRC_INIT;
        chk_c = q.verify_en && !q.rx_off;
        d.chk_on = chk_c;
      end
      crc_c = crc_byte(crc_c, i_rx.data);
      d.crc = crc_c;
      d.in_frame = !i_rx.eop;
      if (i_rx.eop) begin
        d.fcs_err = chk_c && (crc_c != CRC_RESIDUE);
      end
    end
  end

  // state register; reset gives documented values
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      q <= STATE_RST;
    end else begin
      q <= d;
    end
  end

  // frame stage owns the delay line and the live path state
  rx_frame_trim u_trim (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_cfg      (cfg),
    .i_beat     (i_rx),
    .o_beat     (o_receive_stream_data_out),
    .o_path_off (path_off)
  );

  // outputs all come from flip-flops
  assign o_csr_rdata   = q.rdata;
  assign o_csr_rdvalid = q.rdvalid;
  assign o_fcs_err     = q.fcs_err;

  // helper: bytes delivered in the current output frame
  logic [15:0] out_len_q;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_len_q <= 16'h0;
    end else if (o_receive_stream_data_out.valid) begin
      out_len_q <= o_receive_stream_data_out.sop ? 16'h1
                                                 : out_len_q + 16'h1;
    end
  end

  property p_drop_frame;
    i_rx.valid && i_rx.sop && q.rx_off |=>
      !o_receive_stream_data_out.valid;
  endproperty
  a_drop_frame: assert property (p_drop_frame)
    else $error("byte delivered from a dropped frame");

  property p_status_read;
    i_csr.read && hit_stat |=>
      o_csr_rdvalid && o_csr_rdata == {31'h0, $past(path_off)};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read does not show path state");

  property p_idle_status;
    !q.in_frame && !i_rx.valid && !u_trim.q.in_frame ##1
      !i_rx.valid |-> path_off == $past(q.rx_off);
  endproperty
  a_idle_status: assert property (p_idle_status)
    else $error("idle path state does not follow control bit");

  property p_fcs_keep;
    i_rx.valid && i_rx.sop && !q.rx_off && !q.fcs_strip &&
      !q.pad_strip |=>
      o_receive_stream_data_out.valid &&
      o_receive_stream_data_out.sop &&
      o_receive_stream_data_out.data == $past(i_rx.data);
  endproperty
  a_fcs_keep: assert property (p_fcs_keep)
    else $error("fcs kept frame not passed straight through");

  property p_fcs_strip_delay;
    i_rx.valid && i_rx.sop && !q.rx_off && q.fcs_strip &&
      !q.pad_strip |-> ##1 (!o_receive_stream_data_out.valid)[*4];
  endproperty
  a_fcs_strip_delay: assert property (p_fcs_strip_delay)
    else $error("fcs strip did not hold back four bytes");

  property p_pad_wins;
    i_rx.valid && i_rx.sop && !q.rx_off && q.pad_strip &&
      !q.fcs_strip |-> ##1 (!o_receive_stream_data_out.valid)[*4];
  endproperty
  a_pad_wins: assert property (p_pad_wins)
    else $error("pad strip bit did not force fcs removal");

  property p_pad_min_len;
    o_receive_stream_data_out.valid && o_receive_stream_data_out.eop &&
      !o_receive_stream_data_out.sop && u_trim.q.pad_rm |->
      out_len_q + 16'h1 >= 16'(HDR_LEN);
  endproperty
  a_pad_min_len: assert property (p_pad_min_len)
    else $error("pad strip cut into the header");

  property p_no_byte_after_eop;
    o_receive_stream_data_out.valid &&
      o_receive_stream_data_out.eop |=>
      !(o_receive_stream_data_out.valid &&
        !o_receive_stream_data_out.sop);
  endproperty
  a_no_byte_after_eop: assert property (p_no_byte_after_eop)
    else $error("byte delivered after end of frame");

  property p_err_cause;
    o_fcs_err |-> $past(i_rx.valid && i_rx.eop) && q.chk_on;
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("fcs error without a checked frame end");

  property p_reserved_zero;
    i_csr.read && !hit_ctrl && !hit_stat && !hit_strip &&
      !hit_verify |=> o_csr_rdvalid && o_csr_rdata == 32'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved offset read not zero");

  property p_verify_bits;
    i_csr.read && hit_verify |=>
      o_csr_rdata[31:2] == 30'h0 && !o_csr_rdata[0];
  endproperty
  a_verify_bits: assert property (p_verify_bits)
    else $error("reserved verify bits read non-zero");

  property p_strip_write;
    i_csr.write && hit_strip ##1 !i_csr.write ##1
      i_csr.read && hit_strip && !i_csr.write |=>
      o_csr_rdata == {30'h0, $past(i_csr.wdata[1:0], 3)};
  endproperty
  a_strip_write: assert property (p_strip_write)
    else $error("strip register readback mismatch");

  property p_ctrl_write;
    i_csr.write && hit_ctrl |=>
      q.rx_off == $past(i_csr.wdata[BIT_RX_OFF]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("receive-enable write not stored");

  property p_rd_idle;
    !i_csr.read |=> !o_csr_rdvalid && o_csr_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data standing without a read");

  property p_verify_off;
    i_rx.valid && i_rx.sop && !q.verify_en |=> !q.chk_on;
  endproperty
  a_verify_off: assert property (p_verify_off)
    else $error("frame checked with verification off");

  property p_off_unchecked;
    i_rx.valid && i_rx.sop && q.rx_off |=> !q.chk_on;
  endproperty
  a_off_unchecked: assert property (p_off_unchecked)
    else $error("dropped frame still checked");

  c_strip_frame: cover property (
    u_trim.q.fcs_rm && o_receive_stream_data_out.valid &&
    o_receive_stream_data_out.eop);
  c_pad_cut: cover property (
    u_trim.q.pad_rm && u_trim.q.len < 16'(MIN_PAYLOAD) &&
    o_receive_stream_data_out.valid && o_receive_stream_data_out.eop);
  c_fcs_err: cover property (o_fcs_err);
  c_dropped: cover property (i_rx.valid && i_rx.sop && q.rx_off);
  c_status_off: cover property (i_csr.read && hit_stat && path_off);

endmodule

// >>> bench/tb_rx_path_control_regs.sv
// self-checking bench for the receive-path control registers
// assumes the csr port and receive stream share i_clk; inputs change
// on the falling edge so the rising edge always sees settled values
`timescale 1ns/100ps

`define CHK(name, exp, got) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("mismatch %s expected %0h seen %0h", name, exp, got); \
  end \
end

module tb_rx_path_control_regs;
  import rx_ctrl_pkg::*;

  logic        clk      = 1'b0;
  logic        sys_rst  = 1'b1;
  csr_req_s    csr;
  rx_beat_s    rx;
  rx_beat_s    rxo;
  logic [31:0] rdata;
  logic        rdvalid;
  logic        fcs_err;
  int          bad_count  = 0;
  int          num_checks = 0;
  int          err_seen   = 0;
  logic [31:0] seed       = 32'hb97d;
  logic [9:0]  got_q[$];
  logic [9:0]  exp_q[$];
  logic [7:0]  fr[$];

  // 250 mhz clock
  always #2 clk = ~clk;

  rx_path_control_regs u_dut (
    .i_clk                     (clk),
    .i_sys_rst                 (sys_rst),
    .i_csr                     (csr),
    .o_csr_rdata               (rdata),
    .o_csr_rdvalid             (rdvalid),
    .i_rx                      (rx),
    .o_receive_stream_data_out (rxo),
    .o_fcs_err                 (fcs_err)
  );

  // capture delivered bytes and error pulses as they stand
  always @(posedge clk) begin
    if (rxo.valid !== 1'b0) got_q.push_back({rxo.sop, rxo.eop, rxo.data});
    if (fcs_err !== 1'b0) err_seen++;
  end

  // repeatable pseudo-random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // bench's own crc over the first n frame bytes, complemented
  function automatic logic [31:0] crc_of(input int n);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {24'h0, fr[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    return ~c;
  endfunction

  task automatic csr_wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    csr.write = 1'b1;
    csr.addr  = a;
    csr.wdata = d;
    @(negedge clk);
    csr.write = 1'b0;
  endtask

  // answer stands in the cycle after the taking edge
  task automatic csr_rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge clk);
    csr.read = 1'b1;
    csr.addr = a;
    @(negedge clk);
    csr.read = 1'b0;
    `CHK("rdvalid", 1'b1, rdvalid)
    `CHK("rdata", e, rdata)
  endtask

  // build one frame, send it back to back and compare what comes out
  task automatic run_frame(input logic [1:0] mode, input bit off,
                           input bit chk, input bit bad, input int n,
                           input int len);
    logic [31:0] r;
    logic [31:0] c;
    int          m;
    fr.delete();
    for (int i = 0; i < n - 4; i++) begin
      r = xs();
      if (i == 12) fr.push_back(len[15:8]);
      else if (i == 13) fr.push_back(len[7:0]);
      else fr.push_back(r[7:0]);
    end
    c = crc_of(n - 4);
    if (bad) c = c ^ 32'h0000_0100;
    for (int k = 0; k < 4; k++) fr.push_back(c[8*k +: 8]);
    m = (mode != 2'h0) ? n - 4 : n;
    if (mode[1] && len < MIN_PAYLOAD && HDR_LEN + len < m) m = HDR_LEN + len;
    if (off) m = 0;
    for (int i = 0; i < m; i++) exp_q.push_back({i == 0, i == m - 1, fr[i]});
    got_q.delete();
    err_seen = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      rx = {1'b1, i == 0, i == n - 1, fr[i]};
    end
    @(negedge clk);
    rx = '0;
    repeat (8) @(negedge clk);
    `CHK("out_len", exp_q.size(), got_q.size())
    for (int i = 0; i < m && i < got_q.size(); i++) begin
      `CHK("out_byte", exp_q[i], got_q[i])
    end
    `CHK("fcs_err", int'(chk && bad && !off), err_seen)
    exp_q.delete();
  endtask

  task automatic final_report();
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // cut a hang short well beyond the expected run of under two thousand cycles
  initial begin
    #100000;
    bad_count++;
    final_report();
  end

  logic [7:0]  res_tab[6] = '{8'h02, 8'h3f, 8'h41, 8'h7f, 8'h81, 8'hbf};
  logic [31:0] r;
  logic [7:0]  a;

  initial begin
    csr = '0;
    rx  = '0;
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    // reset values of every mapped word
    csr_rd(OFS_ENA_CTRL, RST_ENA_CTRL);
    csr_rd(OFS_ENA_STAT, 32'h0);
    csr_rd(OFS_STRIP, RST_STRIP);
    csr_rd(OFS_VERIFY, RST_VERIFY);
    // reserved bits drop writes; verify bit 0 kept at zero by software
    csr_wr(OFS_STRIP, 32'hffff_fffc);
    csr_rd(OFS_STRIP, 32'h0);
    csr_wr(OFS_VERIFY, 32'hffff_fffe);
    csr_rd(OFS_VERIFY, 32'h2);
    // reserved offsets up to 0xbf: range edges, then random picks inside each range
    for (int k = 0; k < 12; k++) begin
      r = xs();
      if (k < 6) a = res_tab[k];
      else if (k % 3 == 0) a = 8'h02 + 8'(r % 62);
      else if (k % 3 == 1) a = 8'h41 + 8'(r % 63);
      else a = 8'h81 + 8'(r % 63);
      csr_wr(a, xs());
      csr_rd(a, 32'h0);
    end
    csr_rd(OFS_STRIP, 32'h0);
    // every strip mode, short pad and full payload
    for (int mo = 0; mo < 4; mo++) begin
      csr_wr(OFS_STRIP, 32'(mo));
      run_frame(2'(mo), 1'b0, 1'b1, 1'b0, 64, 10);
      run_frame(2'(mo), 1'b0, 1'b1, 1'b0, 72, 54);
    end
    // check sequence: bad with checking on, then off
    run_frame(2'h3, 1'b0, 1'b1, 1'b1, 64, 45);
    csr_wr(OFS_VERIFY, 32'h0);
    run_frame(2'h3, 1'b0, 1'b0, 1'b1, 64, 45);
    // receive path off drops whole frames and shows in status
    csr_wr(OFS_ENA_CTRL, 32'hffff_ffff);
    csr_rd(OFS_ENA_CTRL, 32'h1);
    csr_rd(OFS_ENA_STAT, 32'h1);
    run_frame(2'h0, 1'b1, 1'b0, 1'b1, 64, 20);
    csr_wr(OFS_ENA_CTRL, 32'h0);
    csr_rd(OFS_ENA_STAT, 32'h0);
    csr_wr(OFS_STRIP, 32'h1);
    run_frame(2'h1, 1'b0, 1'b0, 1'b0, 64, 20);
    // random mix of mode, length, check enable and corruption
    for (int k = 0; k < 8; k++) begin
      r = xs();
      // strip and verify change with the stream idle
      csr_wr(OFS_STRIP, {30'h0, r[1:0]});
      csr_wr(OFS_VERIFY, {30'h0, r[2], 1'b0});
      run_frame(r[1:0], 1'b0, r[2], r[3], 60 + int'(r[10:6]),
                1 + int'(r[16:11] % 60));
    end
    final_report();
  end

endmodule
